// ---- common/serial_pkg.sv ----
// Package: register map, field layout and state codes of the serial block
package serial_pkg;
	localparam int          CHANNELS    = 12;
	localparam int          ADDR_W      = 12;
	// Global registers
	localparam logic [11:0] ADDR_STOP   = 12'h000;
	localparam logic [11:0] ADDR_PROT   = 12'h004;
	localparam logic [11:0] ADDR_GROUP  = 12'h008;
	// Channel blocks: base, region tag and index field
	localparam logic [2:0]  CHAN_REGION = 3'h1;
	localparam int          REGION_LSB  = 9;
	localparam int          IDX_LSB     = 5;
	localparam int          IDX_W       = 4;
	// Register offsets inside one channel block
	localparam logic [4:0]  REG_CTRL    = 5'h00;
	localparam logic [4:0]  REG_EXT     = 5'h04;
	localparam logic [4:0]  REG_NF      = 5'h08;
	localparam logic [4:0]  REG_BAUD    = 5'h0C;
	localparam logic [4:0]  REG_TDATA   = 5'h10;
	localparam logic [4:0]  REG_RDATA   = 5'h14;
	localparam logic [4:0]  REG_FLAG    = 5'h18;
	localparam logic [4:0]  REG_MASK    = 5'h1C;
	// Control fields
	localparam int          CTRL_RX_EN  = 0;
	localparam int          CTRL_TX_EN  = 1;
	localparam int          CTRL_PAR_EN = 2;
	localparam int          CTRL_ODD    = 3;
	localparam int          CTRL_W      = 4;
	// Extended mode fields
	localparam int          EXT_SRC_LSB = 0;
	localparam int          EXT_BASE8   = 2;
	localparam int          EXT_NF_EN   = 3;
	localparam int          EXT_W       = 4;
	localparam logic [1:0]  SRC_INT     = 2'h0;
	localparam logic [1:0]  SRC_EXT     = 2'h1;
	localparam logic [1:0]  SRC_TIMER   = 2'h2;
	localparam int          NF_W        = 2;
	localparam int          BAUD_W      = 16;
	localparam logic [15:0] BAUD_RESET  = 16'h0000;
	// Flag layout: err, rx full, tx empty, tx end, overrun, framing, parity
	localparam int          FLAG_ERR    = 0;
	localparam int          FLAG_W      = 7;
	localparam logic [31:0] PROT_KEY    = 32'h0000A501;
	localparam logic [4:0]  OVS_FAST    = 5'h08;
	localparam logic [4:0]  OVS_SLOW    = 5'h10;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
	localparam logic [1:0]  HTRANS_SEQ  = 2'h3;
	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_START = 5'h02,
		S_DATA  = 5'h04,
		S_PAR   = 5'h08,
		S_STOP  = 5'h10
	} ser_state_type;
endpackage

// ---- common/chan_if.sv ----
// Interface: settings and events between the register block and one channel
`timescale 1ns/100ps
`default_nettype none
interface chan_if;
	logic       run;
	logic       rx_en;
	logic       tx_en;
	logic       par_en;
	logic       par_odd;
	logic       base8;
	logic       nf_en;
	logic [1:0] nf_sel;
	logic       tick;
	logic       rxd;
	logic       rx_unread;
	logic       tx_avail;
	logic [7:0] tx_data;
	logic [7:0] rx_data;
	logic       ev_rxf;
	logic       ev_err;
	logic [2:0] err_kind;
	logic       tx_take;
	logic       ev_tei;
	logic       txd;
	modport ctl (output run, rx_en, tx_en, par_en, par_odd, base8, nf_en,
		nf_sel, tick, rxd, rx_unread, tx_avail, tx_data,
		input rx_data, ev_rxf, ev_err, err_kind, tx_take, ev_tei, txd);
	modport chan (input run, rx_en, tx_en, par_en, par_odd, base8, nf_en,
		nf_sel, tick, rxd, rx_unread, tx_avail, tx_data,
		output rx_data, ev_rxf, ev_err, err_kind, tx_take, ev_tei, txd);
endinterface
`default_nettype wire

// ---- logic/uart_channel.sv ----
// One asynchronous channel: noise filter, receiver and transmitter
`timescale 1ns/100ps
`default_nettype none
module uart_channel (
	input  wire logic clk, // Core clock
	input  wire logic rst, // Synchronous reset, active high
	chan_if.chan      ch   // Settings in, events out
);
	serial_pkg::ser_state_type rx_st, next_rx_st, tx_st, next_tx_st;
	logic [4:0] rx_cnt, next_rx_cnt, tx_cnt, next_tx_cnt, ovs, half;
	logic [2:0] rx_bit, next_rx_bit, tx_bit, next_tx_bit;
	logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, rx_out, next_rx_out;
	logic       rx_par, next_rx_par, tx_par, next_tx_par;
	logic       txd, next_txd, rxin, rx_smp, tx_end;
	logic [2:0] nf_sr, next_nf_sr, nf_cnt, next_nf_cnt, nf_mask;
	logic [2:0] kind, next_kind;
	logic       nf_out, next_nf_out;
	logic       rxf, next_rxf, err, next_err, take, next_take;
	logic       tei, next_tei;

	assign ch.rx_data  = rx_out;
	assign ch.ev_rxf   = rxf;
	assign ch.ev_err   = err;
	assign ch.err_kind = kind;
	assign ch.tx_take  = take;
	assign ch.ev_tei   = tei;
	assign ch.txd      = txd;

	always_comb begin
		ovs = ch.base8 ? serial_pkg::OVS_FAST : serial_pkg::OVS_SLOW;
		half = ovs >> 1;
		nf_mask = 3'((4'h1 << ch.nf_sel) - 4'h1);
		rx_smp = ch.tick && (rx_cnt == ovs - 5'h01);
		tx_end = ch.tick && (tx_cnt == ovs - 5'h01);
		rxin = ch.nf_en ? nf_out : ch.rxd;
		next_nf_cnt = ch.tick ? nf_cnt + 3'h1 : nf_cnt;
		next_nf_sr = nf_sr;
		next_nf_out = nf_out;
		// Input moves only after three equal samples
		if (ch.tick && (nf_cnt & nf_mask) == 3'h0) begin
			next_nf_sr = {nf_sr[1:0], ch.rxd};
			if (&next_nf_sr || ~|next_nf_sr)
				next_nf_out = next_nf_sr[0];
		end
		next_rx_st = rx_st;
		next_rx_cnt = ch.tick ? rx_cnt + 5'h01 : rx_cnt;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_par = rx_par;
		next_rx_out = rx_out;
		next_rxf = 1'b0;
		next_err = 1'b0;
		next_kind = 3'h0;
		case (rx_st)
			serial_pkg::S_IDLE: begin
				next_rx_cnt = 5'h00;
				if (ch.rx_en && !rxin)
					next_rx_st = serial_pkg::S_START;
			end
			serial_pkg::S_START: begin
				if (ch.tick && rx_cnt == half - 5'h01) begin
					next_rx_cnt = 5'h00;
					next_rx_bit = 3'h0;
					next_rx_par = ch.par_odd;
					// Glitch shorter than half a bit is not a start
					next_rx_st = rxin ? serial_pkg::S_IDLE
						: serial_pkg::S_DATA;
				end
			end
			serial_pkg::S_DATA: begin
				if (rx_smp) begin
					next_rx_cnt = 5'h00;
					next_rx_sh = {rxin, rx_sh[7:1]};
					next_rx_par = rx_par ^ rxin;
					next_rx_bit = rx_bit + 3'h1;
					if (&rx_bit)
						next_rx_st = ch.par_en ? serial_pkg::S_PAR
							: serial_pkg::S_STOP;
				end
			end
			serial_pkg::S_PAR: begin
				if (rx_smp) begin
					next_rx_cnt = 5'h00;
					next_rx_par = rx_par ^ rxin;
					next_rx_st = serial_pkg::S_STOP;
				end
			end
			serial_pkg::S_STOP: begin
				if (rx_smp) begin
					next_rx_st = serial_pkg::S_IDLE;
					next_kind = {ch.par_en && rx_par, !rxin,
						ch.rx_unread};
					next_err = |next_kind;
					next_rxf = ~|next_kind;
					if (~|next_kind)
						next_rx_out = rx_sh;
				end
			end
			default: next_rx_st = serial_pkg::S_IDLE;
		endcase
		if (!ch.rx_en)
			next_rx_st = serial_pkg::S_IDLE;
		next_tx_st = tx_st;
		next_tx_cnt = ch.tick ? tx_cnt + 5'h01 : tx_cnt;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_tx_par = tx_par;
		next_txd = txd;
		next_take = 1'b0;
		next_tei = 1'b0;
		case (tx_st)
			serial_pkg::S_IDLE: begin
				next_txd = 1'b1;
				next_tx_cnt = 5'h00;
				if (ch.tx_en && ch.tx_avail && !take) begin
					next_take = 1'b1;
					next_tx_sh = ch.tx_data;
					next_tx_par = ch.par_odd;
					next_txd = 1'b0;
					next_tx_st = serial_pkg::S_START;
				end
			end
			serial_pkg::S_START, serial_pkg::S_DATA: begin
				if (tx_end) begin
					next_tx_cnt = 5'h00;
					if (tx_st == serial_pkg::S_DATA && &tx_bit) begin
						next_txd = ch.par_en ? tx_par : 1'b1;
						next_tx_st = ch.par_en ? serial_pkg::S_PAR
							: serial_pkg::S_STOP;
					end else begin
						next_txd = tx_sh[0];
						next_tx_par = tx_par ^ tx_sh[0];
						next_tx_sh = tx_sh >> 1;
						next_tx_bit = (tx_st == serial_pkg::S_START)
							? 3'h0 : tx_bit + 3'h1;
						next_tx_st = serial_pkg::S_DATA;
					end
				end
			end
			serial_pkg::S_PAR: begin
				if (tx_end) begin
					next_tx_cnt = 5'h00;
					next_txd = 1'b1;
					next_tx_st = serial_pkg::S_STOP;
				end
			end
			serial_pkg::S_STOP: begin
				if (tx_end) begin
					next_tx_st = serial_pkg::S_IDLE;
					next_tei = !ch.tx_avail;
				end
			end
			default: next_tx_st = serial_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst || !ch.run) begin
			rx_st <= serial_pkg::S_IDLE;
			tx_st <= serial_pkg::S_IDLE;
			{rx_cnt, tx_cnt} <= 10'h000;
			{rx_bit, tx_bit, nf_cnt, kind} <= 12'h000;
			{rx_sh, tx_sh, rx_out} <= 24'h000000;
			{rx_par, tx_par, rxf, err, take, tei} <= 6'h00;
			nf_sr <= 3'h7;
			nf_out <= 1'b1;
			txd <= 1'b1;
		end else begin
			rx_st <= next_rx_st;
			tx_st <= next_tx_st;
			rx_cnt <= next_rx_cnt;
			tx_cnt <= next_tx_cnt;
			rx_bit <= next_rx_bit;
			tx_bit <= next_tx_bit;
			nf_cnt <= next_nf_cnt;
			kind <= next_kind;
			rx_sh <= next_rx_sh;
			tx_sh <= next_tx_sh;
			rx_out <= next_rx_out;
			rx_par <= next_rx_par;
			tx_par <= next_tx_par;
			rxf <= next_rxf;
			err <= next_err;
			take <= next_take;
			tei <= next_tei;
			nf_sr <= next_nf_sr;
			nf_out <= next_nf_out;
			txd <= next_txd;
		end
	end
endmodule
`default_nettype wire

// ---- logic/serial_async_top.sv ----
// Multi-channel asynchronous serial block with AHB-Lite registers
// Overview of operation
// - Bit period is 8 or 16 ticks
// - Base clock from internal baud counter, external or timer input
// - Only rx full, tx empty start transfers
// - Rx full, tx empty live in irq flags
// - All channel errors share one grouped vector
// - Detect overrun, framing and parity errors
// - Noise filter enabled or bypassed by setting
// - Starts stopped, unconfigurable until released
//
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module serial_async_top #(
	parameter int CHANNELS = serial_pkg::CHANNELS
) (
	input  wire logic                CORE_CLK,      // 100 MHz core clock
	input  wire logic                RST,           // Sync reset, high
	input  wire logic                HSEL,          // Slave select
	input  wire logic [31:0]         HADDR,         // Byte address
	input  wire logic [1:0]          HTRANS,        // Transfer type
	input  wire logic                HWRITE,        // Write when high
	input  wire logic [2:0]          HSIZE,         // Transfer size
	input  wire logic [31:0]         HWDATA,        // Write data
	input  wire logic                HREADY,        // Bus ready
	output logic      [31:0]         HRDATA,        // Read data
	output logic                     HREADYOUT,     // Slave ready
	output logic                     HRESP,         // Always OKAY
	input  wire logic [CHANNELS-1:0] RXD,           // Receive lines
	output logic      [CHANNELS-1:0] TXD,           // Transmit lines
	input  wire logic [CHANNELS-1:0] EXT_CLK,       // External base clocks
	input  wire logic                TIMER_CLK,     // aux_timer_clock
	output logic                     IRQ,           // Any unmasked flag
	output logic                     ERR_GROUP_IRQ, // Grouped error vector
	output logic      [CHANNELS-1:0] RX_DMA_REQ,    // Rx full pulse
	output logic      [CHANNELS-1:0] TX_DMA_REQ     // Tx empty pulse
);
	localparam int CW = serial_pkg::CTRL_W;
	localparam int EW = serial_pkg::EXT_W;
	localparam int NW = serial_pkg::NF_W;
	localparam int BW = serial_pkg::BAUD_W;
	localparam int FW = serial_pkg::FLAG_W;
	localparam int IW = serial_pkg::IDX_W;

	logic [CW-1:0]       ctrl     [CHANNELS], next_ctrl     [CHANNELS];
	logic [EW-1:0]       ext      [CHANNELS], next_ext      [CHANNELS];
	logic [NW-1:0]       nf       [CHANNELS], next_nf       [CHANNELS];
	logic [BW-1:0]       baud     [CHANNELS], next_baud     [CHANNELS];
	logic [BW-1:0]       bcnt     [CHANNELS], next_bcnt     [CHANNELS];
	logic [7:0]          tbuf     [CHANNELS], next_tbuf     [CHANNELS];
	logic [7:0]          rbuf     [CHANNELS], next_rbuf     [CHANNELS];
	logic [FW-1:0]       flag     [CHANNELS], next_flag     [CHANNELS];
	logic [FW-1:0]       mask     [CHANNELS], next_mask     [CHANNELS];
	logic [CHANNELS-1:0] tvalid, next_tvalid, rvalid, next_rvalid;
	logic [CHANNELS-1:0] tick, next_tick, group;
	logic [CHANNELS-1:0] rxd_s1, rxd_s2, eclk_s1, eclk_s2, eclk_s3;
	logic [2:0]          tclk_s;
	logic                stop, next_stop, prot, next_prot;
	logic                dp_wr, next_dp_wr, accept, any_irq;
	logic [11:0]         dp_addr, next_dp_addr, a_addr;
	logic [31:0]         rdata, next_rdata;
	logic                a_hit, d_hit;
	logic [IW-1:0]       a_idx, d_idx;
	logic [4:0]          a_reg, d_reg;
	logic [FW-1:0]       ev [CHANNELS];
	logic [7:0]          rx_data [CHANNELS];
	logic [CHANNELS-1:0] rx_take, tx_take;

	chan_if cif [CHANNELS] ();

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : gen_ch
			assign cif[g].run = !stop;
			assign cif[g].rx_en = ctrl[g][serial_pkg::CTRL_RX_EN];
			assign cif[g].tx_en = ctrl[g][serial_pkg::CTRL_TX_EN];
			assign cif[g].par_en = ctrl[g][serial_pkg::CTRL_PAR_EN];
			assign cif[g].par_odd = ctrl[g][serial_pkg::CTRL_ODD];
			assign cif[g].base8 = ext[g][serial_pkg::EXT_BASE8];
			assign cif[g].nf_en = ext[g][serial_pkg::EXT_NF_EN];
			assign cif[g].nf_sel = nf[g];
			assign cif[g].tick = tick[g];
			assign cif[g].rxd = rxd_s2[g];
			assign cif[g].rx_unread = rvalid[g];
			assign cif[g].tx_avail = tvalid[g];
			assign cif[g].tx_data = tbuf[g];
			assign rx_data[g] = cif[g].rx_data;
			assign rx_take[g] = cif[g].ev_rxf;
			assign tx_take[g] = cif[g].tx_take;
			assign ev[g] = {cif[g].err_kind, cif[g].ev_tei,
				cif[g].tx_take, cif[g].ev_rxf, cif[g].ev_err};
			assign TXD[g] = cif[g].txd;
			// rx full and tx empty only
			assign RX_DMA_REQ[g] = cif[g].ev_rxf;
			assign TX_DMA_REQ[g] = cif[g].tx_take;
			assign group[g] = flag[g][serial_pkg::FLAG_ERR];
			uart_channel u_ch (
				.clk (CORE_CLK),
				.rst (RST),
				.ch  (cif[g])
			);
		end
	endgenerate

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = rdata;
	assign accept = HSEL && HREADY && (HTRANS == serial_pkg::HTRANS_NSEQ
		|| HTRANS == serial_pkg::HTRANS_SEQ);
	assign a_addr = HADDR[11:0];
	assign a_idx = a_addr[serial_pkg::IDX_LSB +: IW];
	assign a_reg = a_addr[serial_pkg::IDX_LSB-1:0];
	assign a_hit = a_addr[11:serial_pkg::REGION_LSB] ==
		serial_pkg::CHAN_REGION && int'(a_idx) < CHANNELS;
	assign d_idx = dp_addr[serial_pkg::IDX_LSB +: IW];
	assign d_reg = dp_addr[serial_pkg::IDX_LSB-1:0];
	assign d_hit = dp_addr[11:serial_pkg::REGION_LSB] ==
		serial_pkg::CHAN_REGION && int'(d_idx) < CHANNELS;

	always_comb begin
		any_irq = 1'b0;
		ERR_GROUP_IRQ = 1'b0;
		for (int c = 0; c < CHANNELS; c++) begin
			any_irq = any_irq | |(flag[c] & mask[c]);
			ERR_GROUP_IRQ = ERR_GROUP_IRQ |
				(group[c] & mask[c][serial_pkg::FLAG_ERR]);
		end
		IRQ = any_irq;
	end

	always_comb begin
		next_dp_wr = accept && HWRITE;
		next_dp_addr = a_addr;
		next_stop = stop;
		next_prot = prot;
		next_rdata = 32'h00000000;
		if (accept && !HWRITE) begin
			if (a_addr == serial_pkg::ADDR_STOP)
				next_rdata = {31'h00000000, stop};
			else if (a_addr == serial_pkg::ADDR_PROT)
				next_rdata = {31'h00000000, prot};
			else if (a_addr == serial_pkg::ADDR_GROUP)
				next_rdata = 32'(group);
			else if (a_hit && a_reg == serial_pkg::REG_CTRL)
				next_rdata = 32'(ctrl[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_EXT)
				next_rdata = 32'(ext[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_NF)
				next_rdata = 32'(nf[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_BAUD)
				next_rdata = 32'(baud[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_RDATA)
				next_rdata = 32'(rbuf[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_FLAG)
				next_rdata = 32'(flag[a_idx]);
			else if (a_hit && a_reg == serial_pkg::REG_MASK)
				next_rdata = 32'(mask[a_idx]);
		end
		// key opens the stop control once
		if (dp_wr && dp_addr == serial_pkg::ADDR_PROT)
			next_prot = HWDATA == serial_pkg::PROT_KEY;
		else if (dp_wr && dp_addr == serial_pkg::ADDR_STOP && prot) begin
			next_stop = HWDATA[0];
			next_prot = 1'b0;
		end
		for (int c = 0; c < CHANNELS; c++) begin
			next_ctrl[c] = ctrl[c];
			next_ext[c] = ext[c];
			next_nf[c] = nf[c];
			next_baud[c] = baud[c];
			next_mask[c] = mask[c];
			next_tbuf[c] = tbuf[c];
			next_tvalid[c] = tvalid[c] && !tx_take[c];
			next_rbuf[c] = rbuf[c];
			next_rvalid[c] = rvalid[c];
			next_flag[c] = flag[c];
			next_bcnt[c] = bcnt[c] + 16'h0001;
			next_tick[c] = 1'b0;
			if (bcnt[c] >= baud[c])
				next_bcnt[c] = 16'h0000;
			case (ext[c][serial_pkg::EXT_SRC_LSB +: 2])
				serial_pkg::SRC_INT: next_tick[c] = bcnt[c] >= baud[c];
				serial_pkg::SRC_EXT: next_tick[c] = eclk_s2[c] && !eclk_s3[c];
				serial_pkg::SRC_TIMER: next_tick[c] = tclk_s[1] && !tclk_s[2];
				default: next_tick[c] = 1'b0;
			endcase
			// Reads that consume data or flags
			if (accept && !HWRITE && a_hit && a_idx == IW'(c)) begin
				if (a_reg == serial_pkg::REG_RDATA)
					next_rvalid[c] = 1'b0;
				if (a_reg == serial_pkg::REG_FLAG)
					next_flag[c] = {FW{1'b0}};
			end
			if (dp_wr && !stop && d_hit && d_idx == IW'(c)) begin
				if (d_reg == serial_pkg::REG_CTRL)
					next_ctrl[c] = HWDATA[CW-1:0];
				else if (d_reg == serial_pkg::REG_EXT)
					next_ext[c] = HWDATA[EW-1:0];
				else if (d_reg == serial_pkg::REG_NF)
					next_nf[c] = HWDATA[NW-1:0];
				else if (d_reg == serial_pkg::REG_BAUD)
					next_baud[c] = HWDATA[BW-1:0];
				else if (d_reg == serial_pkg::REG_MASK)
					next_mask[c] = HWDATA[FW-1:0];
				else if (d_reg == serial_pkg::REG_TDATA) begin
					next_tbuf[c] = HWDATA[7:0];
					next_tvalid[c] = 1'b1;
				end
			end
			// events land in irq flags; set beats clear
			next_flag[c] = next_flag[c] | ev[c];
			if (rx_take[c]) begin
				next_rbuf[c] = rx_data[c];
				next_rvalid[c] = 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		rxd_s1 <= RXD;
		rxd_s2 <= rxd_s1;
		eclk_s1 <= EXT_CLK;
		eclk_s2 <= eclk_s1;
		eclk_s3 <= eclk_s2;
		tclk_s <= {tclk_s[1:0], TIMER_CLK};
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			stop <= 1'b1;
			prot <= 1'b0;
			dp_wr <= 1'b0;
			dp_addr <= 12'h000;
			rdata <= 32'h00000000;
			tvalid <= '0;
			rvalid <= '0;
			tick <= '0;
			for (int c = 0; c < CHANNELS; c++) begin
				ctrl[c] <= '0;
				ext[c] <= '0;
				nf[c] <= '0;
				baud[c] <= serial_pkg::BAUD_RESET;
				bcnt[c] <= 16'h0000;
				tbuf[c] <= 8'h00;
				rbuf[c] <= 8'h00;
				flag[c] <= '0;
				mask[c] <= '0;
			end
		end else begin
			stop <= next_stop;
			prot <= next_prot;
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			rdata <= next_rdata;
			tvalid <= next_tvalid;
			rvalid <= next_rvalid;
			tick <= next_tick;
			for (int c = 0; c < CHANNELS; c++) begin
				ctrl[c] <= next_ctrl[c];
				ext[c] <= next_ext[c];
				nf[c] <= next_nf[c];
				baud[c] <= next_baud[c];
				bcnt[c] <= next_bcnt[c];
				tbuf[c] <= next_tbuf[c];
				rbuf[c] <= next_rbuf[c];
				flag[c] <= next_flag[c];
				mask[c] <= next_mask[c];
			end
		end
	end
endmodule
`default_nettype wire

// ---- testbench/serial_async_checker.sv ----
// Checker: bus answer and event-output timing of the serial block
`timescale 1ns/100ps
`default_nettype none
module serial_async_checker #(
	parameter int CHANNELS = 12
) (
	input wire logic                CORE_CLK,      // Core clock
	input wire logic                RST,           // Reset
	input wire logic [1:0]          HTRANS,        // Transfer type
	input wire logic                HWRITE,        // Write
	input wire logic [31:0]         HRDATA,        // Read data
	input wire logic                HREADYOUT,     // Ready
	input wire logic                HRESP,         // Response
	input wire logic [CHANNELS-1:0] TXD,           // Tx lines
	input wire logic                IRQ,           // Flag irq
	input wire logic                ERR_GROUP_IRQ, // Error irq
	input wire logic [CHANNELS-1:0] RX_DMA_REQ,    // Rx pulses
	input wire logic [CHANNELS-1:0] TX_DMA_REQ     // Tx pulses
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// A start bit lasts one bit period of at least eight ticks
	sequence start_bit;
		!TXD[0] [*7];
	endsequence
	sequence rx_event;
		RX_DMA_REQ[0] ##1 !RX_DMA_REQ[0];
	endsequence
	a_resp_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus answer not ready or not okay");
	a_rdata_idle: assert property (
		!$past(HTRANS[1] && !HWRITE) |-> HRDATA == 32'h0)
		else $error("read data outside a data phase");
	a_stop_quiet: assert property (
		$fell(RST) |-> &TXD && !IRQ && !ERR_GROUP_IRQ
		&& RX_DMA_REQ == '0 && TX_DMA_REQ == '0)
		else $error("outputs busy after reset");
	a_start_hold: assert property ($fell(TXD[0]) |=> start_bit)
		else $error("start bit shorter than eight ticks");
	a_tx_take: assert property (
		TX_DMA_REQ[0] |-> ##[0:2] !TXD[0])
		else $error("tx request without a start bit");
	a_rx_pulse: assert property ($rose(RX_DMA_REQ[0]) |-> rx_event)
		else $error("rx request longer than one cycle");
	a_tx_pulse: assert property (TX_DMA_REQ[0] |=> !TX_DMA_REQ[0])
		else $error("tx request longer than one cycle");
	a_err_irq: assert property (ERR_GROUP_IRQ |-> IRQ)
		else $error("group error without interrupt");
	a_err_nodma: assert property (
		$rose(ERR_GROUP_IRQ) |-> RX_DMA_REQ == '0)
		else $error("receive error started a transfer");
endmodule
bind serial_async_top serial_async_checker #(.CHANNELS(CHANNELS)) chk (
	.CORE_CLK, .RST, .HTRANS, .HWRITE, .HRDATA, .HREADYOUT, .HRESP,
	.TXD, .IRQ, .ERR_GROUP_IRQ, .RX_DMA_REQ, .TX_DMA_REQ);
`default_nettype wire

// ---- testbench/remote_uart.sv ----
// Model: far-end asynchronous transceiver on channel 0
`timescale 1ns/100ps
`default_nettype none
module remote_uart (
	input  wire logic clk,      // Core clock
	output logic      line_out, // To device rx
	input  wire logic line_in   // From device tx
);
	initial line_out = 1'b1;
	task automatic send(input logic [7:0] d, input logic stp, input int ovs);
		logic [9:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (ovs) @(posedge clk);
		end
		// Only a broken stop needs the line put back to idle
		if (!stp) begin
			line_out <= 1'b1;
			@(posedge clk);
		end
	endtask
	// Samples near mid-bit, LSB first
	task automatic recv(output logic [7:0] d, output bit ok, input int ovs);
		int k;
		k = 0;
		d = 8'h00;
		while (line_in !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
		repeat (ovs / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (ovs) @(posedge clk);
			d[i] = line_in;
		end
		repeat (ovs) @(posedge clk);
		ok = k < 400 && line_in === 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- testbench/tb_serial_async_clock_irq.sv ----
// Testbench: register, line and event checks of the serial block
`timescale 1ns/100ps
`default_nettype none
module tb_serial_async_clock_irq;
	logic        core_clk;
	logic        rst;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        rx_line;
	logic        tmr_clk;
	logic [11:0] txd;
	logic        irq;
	logic        err_irq;
	logic [11:0] rx_dma;
	logic [11:0] tx_dma;
	logic [7:0]  q;
	bit          ok;
	int          n_errors;
	int          comparisons;
	int          n_rx;
	int          n_tx;
	serial_async_top uut (
		.CORE_CLK      (core_clk),
		.RST           (rst),
		.HSEL          (1'b1),
		.HADDR         (haddr),
		.HTRANS        (htrans),
		.HWRITE        (hwrite),
		.HSIZE         (3'h2),
		.HWDATA        (hwdata),
		.HREADY        (hreadyout),
		.HRDATA        (hrdata),
		.HREADYOUT     (hreadyout),
		.HRESP         (),
		.RXD           ({11'h7FF, rx_line}),
		.TXD           (txd),
		.EXT_CLK       (12'h000),
		.TIMER_CLK     (tmr_clk),
		.IRQ           (irq),
		.ERR_GROUP_IRQ (err_irq),
		.RX_DMA_REQ    (rx_dma),
		.TX_DMA_REQ    (tx_dma)
	);
	remote_uart u_far (
		.clk      (core_clk),
		.line_out (rx_line),
		.line_in  (txd[0])
	);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Timer base clock: one rising edge every two core cycles
	always @(posedge core_clk) begin
		tmr_clk <= ~tmr_clk;
	end
	always @(posedge core_clk) begin
		if (rx_dma[0] === 1'b1)
			n_rx++;
		if (tx_dma[0] === 1'b1)
			n_tx++;
	end
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			n_errors++;
			wrap_up;
		end
	endtask
	task automatic wait_hi(input logic err);
		int k;
		k = 0;
		while ((err ? err_irq : irq) !== 1'b1 && k < 300) begin
			@(posedge core_clk);
			k++;
		end
		if ((err ? err_irq : irq) !== 1'b1) begin
			n_errors++;
			wrap_up;
		end
	endtask
	// Single word transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		htrans <= serial_pkg::HTRANS_NSEQ;
		haddr <= {20'h00000, a};
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		r = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask
	initial begin
		rst = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		tmr_clk = 1'b0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rd(12'h000, 32'h1);
		wr(12'h200, 32'h3);
		rd(12'h200, 32'h0);
		wr(12'h000, 32'h0);
		rd(12'h000, 32'h1);
		wr(12'h004, serial_pkg::PROT_KEY);
		wr(12'h000, 32'h0);
		rd(12'h000, 32'h0);
		wr(12'h0F0, 32'h5);
		rd(12'h0F0, 32'h0);
		wr(12'h20C, 32'h0);
		wr(12'h21C, 32'h7F);
		wr(12'h208, 32'h0);
		wr(12'h200, 32'h3);
		// Third pass takes its ticks from the timer input
		for (int i = 0; i < 3; i++) begin
			wr(12'h204, i == 0 ? 32'h4 : i == 1 ? 32'h8 : 32'h6);
			u_far.send(i == 0 ? 8'hA5 : i == 1 ? 8'h5A : 8'hC3,
				1'b1, i ? 16 : 8);
			wait_hi(1'b0);
			rd(12'h218, 32'h2);
			chk({31'h0, irq}, 32'h0);
			rd(12'h214, i == 0 ? 32'hA5 : i == 1 ? 32'h5A : 32'hC3);
		end
		chk(32'(n_rx), 32'h3);
		wr(12'h204, 32'h0);
		u_far.send(8'h11, 1'b1, 16);
		u_far.send(8'h22, 1'b1, 16);
		wait_hi(1'b1);
		rd(12'h218, 32'h13);
		rd(12'h214, 32'h11);
		u_far.send(8'h33, 1'b0, 16);
		wait_hi(1'b1);
		rd(12'h008, 32'h1);
		rd(12'h218, 32'h21);
		chk({31'h0, err_irq}, 32'h0);
		chk(32'(n_rx), 32'h4);
		fork
			u_far.recv(q, ok, 16);
			wr(12'h210, 32'h3C);
		join
		chk({24'h0, q}, 32'h3C);
		chk({31'h0, ok}, 32'h1);
		chk(32'(n_tx), 32'h1);
		repeat (16) @(posedge core_clk);
		rd(12'h218, 32'hC);
		wrap_up;
	end
endmodule
`default_nettype wire
